// >>> epc_pkg.sv
// Constants, register map and types for the encoder and pulse-width counter.
// Assumes a 40 MHz system clock and an 8-bit Avalon-MM byte address.
package epc_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_BLK = 4;
  localparam int NUM_SSI = 2;
  localparam int CNT_W   = 32;
  localparam int CFG_W   = 10;
  localparam int ADDR_W  = 8;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS        = 25;
  localparam int SSI_PAUSE_NS  = 20000;
  localparam int SSI_PAUSE_CYC = (SSI_PAUSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SSI_PAUSE_W   = 10;

  // ---------------------------------------------------------------
  // Counter block window: base = block * 0x20
  // ---------------------------------------------------------------
  localparam logic [4:0] R_CFG    = 5'h00;
  localparam logic [4:0] R_CMD    = 5'h04;
  localparam logic [4:0] R_COUNT  = 5'h08;
  localparam logic [4:0] R_LATCH  = 5'h0c;
  localparam logic [4:0] R_HIGH   = 5'h10;
  localparam logic [4:0] R_LOW    = 5'h14;
  localparam logic [4:0] R_PERIOD = 5'h18;

  // counter_mode_config fields
  localparam int CB_EN          = 0;
  localparam int CB_QUAD        = 1;
  localparam int CB_INV_CLK     = 2;
  localparam int CB_INV_DIR     = 3;
  localparam int CB_CLR_PERMIT  = 4;
  localparam int CB_CAP_PERMIT  = 5;
  localparam int CB_REF_ONLY    = 6;
  localparam int CB_PW_EN       = 7;
  localparam int CB_PW_SRC      = 8;
  localparam int CB_PW_FALL     = 9;
  localparam logic [CFG_W-1:0] CFG_RST = 10'h000;
  localparam int CMD_LATCH      = 0;
  localparam int CMD_CLEAR      = 1;

  // ---------------------------------------------------------------
  // SSI decoder window: base = 0x80 + decoder * 0x10
  // ---------------------------------------------------------------
  localparam logic [7:0] SSI_BASE   = 8'h80;
  localparam logic [3:0] S_CFG      = 4'h0;
  localparam logic [3:0] S_CMD      = 4'h4;
  localparam logic [3:0] S_DATA     = 4'h8;
  localparam logic [3:0] S_STAT     = 4'hc;
  localparam int         SC_CONT    = 0;
  localparam int         SC_LEN_LSB = 8;
  localparam int         SC_DIV_LSB = 16;
  localparam int         SSI_START  = 0;
  localparam logic [5:0] LEN_MAX    = 6'h20;
  localparam logic [5:0] LEN_RST    = 6'h20;
  localparam logic [11:0] DIV_MIN   = 12'h001;
  localparam logic [11:0] DIV_RST   = 12'h00f;

  // ---------------------------------------------------------------
  // Event input
  // ---------------------------------------------------------------
  localparam logic [7:0] EVT_CFG  = 8'ha0;
  localparam logic [7:0] EVT_STAT = 8'ha4;

  typedef enum logic [1:0] {SSI_IDLE, SSI_SHIFT, SSI_PAUSE} epc_ssi_st_t;

endpackage

// >>> epc_top.sv
// Four counter blocks, two SSI readers and an event input behind Avalon-MM.
// Assumes the counter, SSI data and event pins are asynchronous to CLK and are synchronised here.
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Four counter blocks, each with its own configuration.
// - Each block holds a 32-bit up/down counter and a pulse-width counter.
// - Both counters of one block run together without interference.
// - Clock/direction mode counts one step per falling clock edge.
// - Direction high counts up, low counts down.
// - Clock and direction inputs can each be inverted by software.
// - Software can latch the counter value at any time.
// - Configuration selects clearing or capturing by the external input.
// - External clear/capture input does nothing unless permitted.
// - Rising edge of the external input performs the permitted action, except a quadrature clear.
// - Quadrature mode converts phases A and B to step and direction.
// - Quadrature mode counts every edge of either phase that does not coincide with an edge of the other.
// - Quadrature clear when A, B and reference are high, or reference only.
// - Software selects the measured pin and the starting edge.
// - High, low and period times are readable directly.
// - Phase pins measure in quadrature mode, clock/direction otherwise.
// - Two SSI decoders are provided.
// - Each SSI decoder reads once on request or continuously.
// - SSI clock rate is programmable by software.
// - SSI word length is programmable up to 32 bits.
// - An enabled event input raises a host trigger.
module epc_top
  import epc_pkg::*;
(
  input  wire logic                      CLK,
  input  wire logic                      RST,
  input  wire logic [epc_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic                      AVS_READ,
  input  wire logic                      AVS_WRITE,
  input  wire logic [31:0]               AVS_WRITEDATA,
  output logic      [31:0]               AVS_READDATA,
  output logic                           AVS_WAITREQUEST,
  input  wire logic [epc_pkg::NUM_BLK-1:0] CNT_A,
  input  wire logic [epc_pkg::NUM_BLK-1:0] CNT_B,
  input  wire logic [epc_pkg::NUM_BLK-1:0] CNT_REF,
  input  wire logic [epc_pkg::NUM_SSI-1:0] SSI_DATA,
  output logic      [epc_pkg::NUM_SSI-1:0] SSI_CLK,
  input  wire logic                      EVENT_IN,
  output logic                           EVENT_TRIG
);
  import epc_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  function automatic logic blk_hit(input logic [7:0] a, input int i,
                                   input logic [4:0] o);
    return !a[7] && a[6:5] == 2'(i) && a[4:0] == o;
  endfunction

  function automatic logic ssi_hit(input logic [7:0] a, input int i,
                                   input logic [3:0] o);
    return a[7:5] == SSI_BASE[7:5] && a[4] == 1'(i) && a[3:0] == o;
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  localparam int NIN = 3 * NUM_BLK + NUM_SSI + 1;
  logic [NIN-1:0]     pin_raw;
  logic [NIN-1:0]     pin_s1;
  logic [NIN-1:0]     pin_s2;
  logic [NIN-1:0]     pin_d;
  logic [NUM_BLK-1:0] pa, pa_d, pb, pb_d, pr, pr_d;
  logic [NUM_SSI-1:0] sd;
  logic               ev, ev_d;

  assign pin_raw = {EVENT_IN, SSI_DATA, CNT_REF, CNT_B, CNT_A};

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_d  <= '0;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
    end
  end

  assign pa   = pin_s2[NUM_BLK-1:0];
  assign pa_d = pin_d[NUM_BLK-1:0];
  assign pb   = pin_s2[2*NUM_BLK-1:NUM_BLK];
  assign pb_d = pin_d[2*NUM_BLK-1:NUM_BLK];
  assign pr   = pin_s2[3*NUM_BLK-1:2*NUM_BLK];
  assign pr_d = pin_d[3*NUM_BLK-1:2*NUM_BLK];
  assign sd   = pin_s2[3*NUM_BLK+NUM_SSI-1:3*NUM_BLK];
  assign ev   = pin_s2[NIN-1];
  assign ev_d = pin_d[NIN-1];

  // ---------------------------------------------------------------
  // Avalon-MM slave: one wait state on every access
  // ---------------------------------------------------------------
  logic        ack;
  logic        req;
  logic        wr;
  logic [31:0] rdata;
  logic [1:0]  bi;
  logic        si;

  assign req             = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack;
  assign wr              = AVS_WRITE & ack;
  assign bi              = AVS_ADDRESS[6:5];
  assign si              = AVS_ADDRESS[4];

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      ack <= 1'b0;
    else
      ack <= req & ~ack;
  end

  // ---------------------------------------------------------------
  // Counter blocks
  // ---------------------------------------------------------------
  logic [CFG_W-1:0]   cfg    [NUM_BLK];
  logic [CNT_W-1:0]   count  [NUM_BLK];
  logic [CNT_W-1:0]   latch  [NUM_BLK];
  logic [CNT_W-1:0]   hi_t   [NUM_BLK];
  logic [CNT_W-1:0]   lo_t   [NUM_BLK];
  logic [CNT_W-1:0]   period [NUM_BLK];
  logic [CNT_W-1:0]   hi_acc [NUM_BLK];
  logic [CNT_W-1:0]   lo_acc [NUM_BLK];
  logic [NUM_BLK-1:0] step, up, ext_clr, ext_cap, sw_lat, sw_clr;
  logic [NUM_BLK-1:0] pw_start, pw_lvl;

  for (genvar g = 0; g < NUM_BLK; g++)
  begin : g_blk
    logic ck, ck_d, quad, sel, sel_d, cmd_we;

    assign quad   = cfg[g][CB_QUAD];
    assign ck     = pa[g] ^ cfg[g][CB_INV_CLK];
    assign ck_d   = pa_d[g] ^ cfg[g][CB_INV_CLK];
    assign cmd_we = wr && blk_hit(AVS_ADDRESS, g, R_CMD);
    assign sw_lat[g] = cmd_we & AVS_WRITEDATA[CMD_LATCH];
    assign sw_clr[g] = cmd_we & AVS_WRITEDATA[CMD_CLEAR];

    // Quadrature: any single phase change steps; both at once is noise
    assign step[g] = cfg[g][CB_EN] & (quad ?
                     ((pa[g] ^ pa_d[g]) ^ (pb[g] ^ pb_d[g])) :
                     rise(ck_d, ck));
    assign up[g]   = quad ? ~(pa_d[g] ^ pb[g]) :
                     pb[g] ^ cfg[g][CB_INV_DIR];

    // Quadrature clear is level based on the reference mark
    assign ext_clr[g] = cfg[g][CB_EN] & cfg[g][CB_CLR_PERMIT] &
                        (quad ? (pr[g] & (cfg[g][CB_REF_ONLY] |
                                 (pa[g] & pb[g]))) :
                         rise(pr[g], pr_d[g]));
    assign ext_cap[g] = cfg[g][CB_EN] & cfg[g][CB_CAP_PERMIT] &
                        rise(pr[g], pr_d[g]);

    // Pin A doubles as clock, pin B as direction
    assign sel   = cfg[g][CB_PW_SRC] ? pb[g] : pa[g];
    assign sel_d = cfg[g][CB_PW_SRC] ? pb_d[g] : pa_d[g];
    assign pw_lvl[g]   = sel;
    assign pw_start[g] = cfg[g][CB_PW_EN] & (cfg[g][CB_PW_FALL] ?
                         rise(sel_d, sel) : rise(sel, sel_d));

    always_ff @(posedge CLK or posedge RST)
    begin
      if (RST)
        cfg[g] <= CFG_RST;
      else if (wr && blk_hit(AVS_ADDRESS, g, R_CFG))
        cfg[g] <= AVS_WRITEDATA[CFG_W-1:0];
    end

    // Clear beats step; arithmetic wraps at the counter width
    always_ff @(posedge CLK or posedge RST)
    begin
      if (RST)
        count[g] <= '0;
      else if (sw_clr[g] | ext_clr[g])
        count[g] <= '0;
      else if (step[g])
        count[g] <= up[g] ? count[g] + 32'h1 : count[g] - 32'h1;
    end

    // Capture takes the value before a same-cycle clear
    always_ff @(posedge CLK or posedge RST)
    begin
      if (RST)
        latch[g] <= '0;
      else if (sw_lat[g] | ext_cap[g])
        latch[g] <= count[g];
    end

    // Own process, shares only the pins with the up/down counter
    always_ff @(posedge CLK or posedge RST)
    begin
      if (RST)
      begin
        hi_acc[g] <= '0;
        lo_acc[g] <= '0;
        hi_t[g]   <= '0;
        lo_t[g]   <= '0;
        period[g] <= '0;
      end
      else if (!cfg[g][CB_PW_EN])
      begin
        hi_acc[g] <= '0;
        lo_acc[g] <= '0;
      end
      else if (pw_start[g])
      begin
        hi_t[g]   <= hi_acc[g];
        lo_t[g]   <= lo_acc[g];
        period[g] <= hi_acc[g] + lo_acc[g];
        hi_acc[g] <= {31'h0, sel};
        lo_acc[g] <= {31'h0, ~sel};
      end
      else if (sel)
        hi_acc[g] <= hi_acc[g] + 32'h1;
      else
        lo_acc[g] <= lo_acc[g] + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // SSI decoders
  // ---------------------------------------------------------------
  epc_ssi_st_t             ssi_st   [NUM_SSI];
  logic [11:0]             ssi_div  [NUM_SSI];
  logic [11:0]             ssi_divc [NUM_SSI];
  logic [5:0]              ssi_len  [NUM_SSI];
  logic [5:0]              ssi_bitc [NUM_SSI];
  logic [31:0]             ssi_sh   [NUM_SSI];
  logic [31:0]             ssi_data [NUM_SSI];
  logic [SSI_PAUSE_W-1:0]  ssi_pc   [NUM_SSI];
  logic [NUM_SSI-1:0]      ssi_cont, ssi_new, ssi_tick, ssi_done, ssi_go;

  for (genvar n = 0; n < NUM_SSI; n++)
  begin : g_ssi
    logic [5:0]  wlen;
    logic [11:0] wdiv;

    assign wlen = AVS_WRITEDATA[SC_LEN_LSB +: 6];
    assign wdiv = AVS_WRITEDATA[SC_DIV_LSB +: 12];
    assign ssi_go[n]   = wr && ssi_hit(AVS_ADDRESS, n, S_CMD) &&
                         AVS_WRITEDATA[SSI_START];
    assign ssi_tick[n] = ssi_st[n] == SSI_SHIFT && ssi_divc[n] == '0;
    assign ssi_done[n] = ssi_tick[n] && !SSI_CLK[n] &&
                         ssi_bitc[n] == 6'h1;

    always_ff @(posedge CLK or posedge RST)
    begin
      if (RST)
      begin
        ssi_cont[n] <= 1'b0;
        ssi_len[n]  <= LEN_RST;
        ssi_div[n]  <= DIV_RST;
      end
      else if (wr && ssi_hit(AVS_ADDRESS, n, S_CFG))
      begin
        ssi_cont[n] <= AVS_WRITEDATA[SC_CONT];
        ssi_len[n]  <= (wlen > LEN_MAX) ? LEN_MAX :
                       (wlen == '0) ? 6'h1 : wlen;
        ssi_div[n]  <= (wdiv < DIV_MIN) ? DIV_MIN : wdiv;
      end
    end

    // Clock idles high; half period is ssi_div + 1 system cycles
    always_ff @(posedge CLK or posedge RST)
    begin
      if (RST)
      begin
        ssi_st[n]   <= SSI_IDLE;
        SSI_CLK[n]  <= 1'b1;
        ssi_divc[n] <= '0;
        ssi_bitc[n] <= '0;
        ssi_sh[n]   <= '0;
        ssi_data[n] <= '0;
        ssi_pc[n]   <= '0;
      end
      else
        case (ssi_st[n])
          SSI_IDLE:
            if (ssi_cont[n] || ssi_go[n])
            begin
              ssi_st[n]   <= SSI_SHIFT;
              ssi_divc[n] <= ssi_div[n];
              ssi_bitc[n] <= ssi_len[n];
              ssi_sh[n]   <= '0;
            end
          SSI_SHIFT:
            if (!ssi_tick[n])
              ssi_divc[n] <= ssi_divc[n] - 12'h1;
            else
            begin
              ssi_divc[n] <= ssi_div[n];
              SSI_CLK[n]  <= ~SSI_CLK[n];
              if (!SSI_CLK[n])
              begin
                ssi_sh[n]   <= {ssi_sh[n][30:0], sd[n]};
                ssi_bitc[n] <= ssi_bitc[n] - 6'h1;
                if (ssi_done[n])
                begin
                  ssi_data[n] <= {ssi_sh[n][30:0], sd[n]};
                  ssi_pc[n]   <= SSI_PAUSE_W'(SSI_PAUSE_CYC);
                  ssi_st[n]   <= SSI_PAUSE;
                end
              end
            end
          SSI_PAUSE:
            // Encoder needs a quiet gap before the next word
            if (ssi_pc[n] == '0)
              ssi_st[n] <= SSI_IDLE;
            else
              ssi_pc[n] <= ssi_pc[n] - 1'b1;
          default:
            ssi_st[n] <= SSI_IDLE;
        endcase
    end

    // New word flag: a completion beats the clearing read
    always_ff @(posedge CLK or posedge RST)
    begin
      if (RST)
        ssi_new[n] <= 1'b0;
      else if (ssi_done[n])
        ssi_new[n] <= 1'b1;
      else if (AVS_READ && ack && ssi_hit(AVS_ADDRESS, n, S_DATA))
        ssi_new[n] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Event input
  // ---------------------------------------------------------------
  logic ev_en;
  logic ev_pend;
  logic ev_hit;

  assign ev_hit = ev_en & rise(ev, ev_d);

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      ev_en <= 1'b0;
    else if (wr && AVS_ADDRESS == EVT_CFG)
      ev_en <= AVS_WRITEDATA[0];
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      ev_pend    <= 1'b0;
      EVENT_TRIG <= 1'b0;
    end
    else
    begin
      EVENT_TRIG <= ev_hit;
      if (ev_hit)
        ev_pend <= 1'b1;
      else if (wr && AVS_ADDRESS == EVT_STAT && AVS_WRITEDATA[0])
        ev_pend <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb
  begin
    rdata = '0;
    if (!AVS_ADDRESS[7])
      case (AVS_ADDRESS[4:0])
        R_CFG:    rdata[CFG_W-1:0] = cfg[bi];
        R_COUNT:  rdata = count[bi];
        R_LATCH:  rdata = latch[bi];
        R_HIGH:   rdata = hi_t[bi];
        R_LOW:    rdata = lo_t[bi];
        R_PERIOD: rdata = period[bi];
        default:  rdata = '0;
      endcase
    else if (AVS_ADDRESS[7:5] == SSI_BASE[7:5])
      case (AVS_ADDRESS[3:0])
        S_CFG:
        begin
          rdata[SC_CONT]           = ssi_cont[si];
          rdata[SC_LEN_LSB +: 6]   = ssi_len[si];
          rdata[SC_DIV_LSB +: 12]  = ssi_div[si];
        end
        S_DATA:   rdata = ssi_data[si];
        S_STAT:   rdata[1:0] = {ssi_st[si] != SSI_IDLE, ssi_new[si]};
        default:  rdata = '0;
      endcase
    else if (AVS_ADDRESS == EVT_CFG)
      rdata[0] = ev_en;
    else if (AVS_ADDRESS == EVT_STAT)
      rdata[0] = ev_pend;
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      AVS_READDATA <= '0;
    else if (req & ~ack)
      AVS_READDATA <= rdata;
  end

  // ---------------------------------------------------------------
  // Checks on block 0, decoder 0 and the event input
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_cd_step;
    (cfg[0][CB_EN] && !cfg[0][CB_QUAD] && !cfg[0][CB_INV_CLK] &&
     !cfg[0][CB_INV_DIR] && pa_d[0] && !pa[0] && !sw_clr[0] &&
     !ext_clr[0]) |=> (count[0] - $past(count[0])) ==
     ($past(pb[0]) ? 32'h1 : 32'hffffffff);
  endproperty
  a_cd_step: assert property (p_cd_step)
    else $error("clock/direction step wrong");

  property p_quad_step;
    (cfg[0][CB_EN] && cfg[0][CB_QUAD] && (pa[0] != pa_d[0]) &&
     (pb[0] == pb_d[0]) && !sw_clr[0] && !ext_clr[0])
    |=> count[0] != $past(count[0]);
  endproperty
  a_quad_step: assert property (p_quad_step)
    else $error("quadrature edge not counted");

  property p_no_permit;
    (!cfg[0][CB_CLR_PERMIT] && !step[0] && !sw_clr[0])
    |=> $stable(count[0]);
  endproperty
  a_no_permit: assert property (p_no_permit)
    else $error("counter moved without cause");

  property p_ext_clear;
    (cfg[0][CB_EN] && cfg[0][CB_CLR_PERMIT] && !cfg[0][CB_QUAD] &&
     pr[0] && !pr_d[0]) |=> count[0] == '0;
  endproperty
  a_ext_clear: assert property (p_ext_clear)
    else $error("external clear missed");

  property p_sw_latch;
    sw_lat[0] |=> latch[0] == $past(count[0]);
  endproperty
  a_sw_latch: assert property (p_sw_latch)
    else $error("software latch wrong");

  property p_pw_period;
    pw_start[0] |=> period[0] == hi_t[0] + lo_t[0] &&
                    (hi_acc[0] + lo_acc[0]) == 32'h1;
  endproperty
  a_pw_period: assert property (p_pw_period)
    else $error("pulse period not high plus low");

  property p_ssi_rate;
    $changed(SSI_CLK[0]) |-> $past(ssi_tick[0]) && !ssi_tick[0];
  endproperty
  a_ssi_rate: assert property (p_ssi_rate)
    else $error("ssi clock off divider");

  property p_event;
    ev_hit |=> EVENT_TRIG && ev_pend;
  endproperty
  a_event: assert property (p_event)
    else $error("event trigger missed");

endmodule
`default_nettype wire

// >>> epc_ssi_enc.sv
// SSI absolute encoder model answering the decoder's clock.
// Assumes the clock idles high and data is taken on rising edges.
`timescale 1ns/100ps
`default_nettype none
module epc_ssi_enc #(
  parameter int          LEN = 12,
  parameter logic [31:0] POS = 32'h0
) (
  input  wire logic sclk,
  output logic      sdata
);
  logic [31:0] sh;
  int          n = 0;
  initial sdata = 1'b1;
  // --------------------------------------
  // Next bit on each falling clock
  // --------------------------------------
  always @(negedge sclk)
  begin
    if (n == 0)
      sh = POS << (32 - LEN);
    sdata <= sh[31];
    sh = sh << 1;
    n++;
  end
  // Frame over: no stale bit left on the line
  always @(posedge sclk)
    if (n == LEN)
    begin
      n = 0;
      sdata <= ~sdata;
    end
endmodule
`default_nettype wire

// >>> encoder_pwm_counter_block_tb.sv
// Self-checking bench for the four-block counter with SSI and event input.
// Assumes the bus answers with one wait state; the watchdog cuts hangs.
`timescale 1ns/100ps
`default_nettype none
module encoder_pwm_counter_block_tb;
  import epc_pkg::*;
  logic        CLK = 0, RST = 1, AVS_READ = 0, AVS_WRITE = 0, EVENT_IN = 0;
  logic [7:0]  AVS_ADDRESS = 0;
  logic [31:0] AVS_WRITEDATA = 0, AVS_READDATA;
  logic        AVS_WAITREQUEST, EVENT_TRIG;
  logic [3:0]  CNT_A = 4'hf, CNT_B = 4'h5, CNT_REF = 0;
  logic [1:0]  SSI_CLK, SSI_DATA;
  int          errors = 0, checks = 0;
  always #12.5 CLK = ~CLK;
  epc_top u_dut (.CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .CNT_A(CNT_A), .CNT_B(CNT_B),
    .CNT_REF(CNT_REF), .SSI_DATA(SSI_DATA), .SSI_CLK(SSI_CLK),
    .EVENT_IN(EVENT_IN), .EVENT_TRIG(EVENT_TRIG));
  epc_ssi_enc #(.LEN(12), .POS(32'h0000_0a5c)) u_enc0 (.sclk(SSI_CLK[0]),
    .sdata(SSI_DATA[0]));
  epc_ssi_enc #(.LEN(32), .POS(32'hc3a5_1e69)) u_enc1 (.sclk(SSI_CLK[1]),
    .sdata(SSI_DATA[1]));
  // --------------------------------------
  // Bus and pin helpers
  // --------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    logic wait_s;
    int   t;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_READ <= !w;
    AVS_WRITE <= w;
    t = 0;
    // Settled values, i.e. what the next rising edge samples
    do
    begin
      @(negedge CLK);
      wait_s = AVS_WAITREQUEST;
      q = AVS_READDATA;
      @(posedge CLK);
      t++;
    end
    while (wait_s !== 1'b0 && t < 50);
    if (wait_s !== 1'b0)
      chk(1, 0);
    AVS_READ <= 0;
    AVS_WRITE <= 0;
    @(posedge CLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    acc(0, a, 0, q);
    chk(q, exp);
  endtask
  // Falling then rising pulse on the masked clock lines
  task automatic pa(input int n, input logic [3:0] m);
    repeat (n)
    begin
      CNT_A <= CNT_A & ~m;
      cyc(2);
      CNT_A <= CNT_A | m;
      cyc(2);
    end
    cyc(4);
  endtask
  task automatic pr(input logic [3:0] m);
    CNT_REF <= m;
    cyc(3);
    CNT_REF <= 0;
    cyc(4);
  endtask
  task automatic qs(input logic a, input logic b);
    CNT_A[2] <= a;
    CNT_B[2] <= b;
    cyc(3);
  endtask
  task automatic pw(input logic useb, input int hi, input int lo);
    repeat (4)
    begin
      if (useb) CNT_B[3] <= 0; else CNT_A[3] <= 0;
      cyc(lo);
      if (useb) CNT_B[3] <= 1; else CNT_A[3] <= 1;
      cyc(hi);
    end
    cyc(4);
  endtask
  task automatic ssi(input logic [7:0] b, input logic [31:0] cfg,
                     input logic [31:0] exp);
    logic [31:0] q;
    int t;
    wr(b, cfg);
    wr(b + 8'h4, 1);
    t = 0;
    do
    begin
      acc(0, b + 8'hc, 0, q);
      t++;
    end
    while (q !== 32'h1 && t < 600);
    chk(q, 32'h1);
    rc(b + 8'h8, exp);
  endtask
  task automatic evt(input logic [31:0] exp);
    int n;
    EVENT_IN <= 1;
    n = 0;
    repeat (8)
    begin
      @(negedge CLK);
      if (EVENT_TRIG === 1'b1) n++;
    end
    @(posedge CLK);
    EVENT_IN <= 0;
    chk(n, exp);
  endtask
  // --------------------------------------
  // Scenarios
  // --------------------------------------
  task automatic t_reset;
    rc(8'h08, 0);
    rc(8'h80, 32'h000f_2000);
    wr(8'h1c, 32'hffff_ffff);
    rc(8'h1c, 0);
  endtask
  task automatic t_cdir;
    for (int b = 0; b < 4; b++) wr(8'(b * 32), 1);
    pa(3, 4'hf);
    for (int b = 0; b < 4; b++)
      rc(8'(b * 32 + 8), (b % 2) ? 32'hffff_fffd : 32'h3);
    CNT_A <= 4'h0;
    cyc(6);
    wr(8'h00, 32'h00d);
    pa(2, 4'h1);
    rc(8'h08, 32'h2);
  endtask
  task automatic t_latch;
    logic [31:0] q1;
    logic [31:0] q2;
    wr(8'h00, 1);
    wr(8'h04, 1);
    rc(8'h0c, 32'h2);
    pr(4'h1);
    rc(8'h08, 32'h2);
    pa(1, 4'h1);
    wr(8'h00, 32'h021);
    pr(4'h1);
    rc(8'h0c, 32'h3);
    wr(8'h00, 32'h011);
    pr(4'h1);
    rc(8'h08, 0);
    wr(8'h04, 1);
    acc(0, 8'h0c, 0, q1);
    pa(3, 4'h1);
    wr(8'h04, 1);
    acc(0, 8'h0c, 0, q2);
    chk(q2 - q1, 3);
  endtask
  task automatic t_quad;
    // Both phases high first; a rise is no step in clock/direction mode
    qs(1, 1);
    wr(8'h44, 2);
    wr(8'h40, 3);
    qs(0, 1);
    qs(0, 0);
    qs(1, 0);
    qs(1, 1);
    rc(8'h48, 32'h4);
    wr(8'h40, 32'h013);
    pr(4'h4);
    rc(8'h48, 0);
    wr(8'h40, 32'h053);
    qs(0, 1);
    pr(4'h4);
    rc(8'h48, 0);
  endtask
  task automatic t_pw;
    wr(8'h60, 32'h081);
    pw(0, 5, 7);
    rc(8'h70, 5);
    rc(8'h74, 7);
    rc(8'h78, 12);
    rc(8'h68, 32'hffff_fff9);
    wr(8'h60, 32'h381);
    pw(1, 4, 6);
    rc(8'h70, 4);
    rc(8'h78, 10);
  endtask
  task automatic t_cont;
    logic [31:0] q;
    int t;
    wr(8'h80, 32'h0003_0c01);
    t = 0;
    do
    begin
      acc(0, 8'h8c, 0, q);
      t++;
    end
    while (q[0] !== 1'b1 && t < 600);
    chk(q[0], 1);
    rc(8'h88, 32'h0000_0a5c);
    wr(8'h80, 32'h0003_0c00);
    t = 0;
    do
    begin
      acc(0, 8'h8c, 0, q);
      t++;
    end
    while (q[1] !== 1'b0 && t < 600);
    chk(q, 32'h0);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    cyc(3);
    RST <= 0;
    cyc(1);
    t_reset();
    t_cdir();
    t_latch();
    t_quad();
    t_pw();
    ssi(8'h80, 32'h0003_0c00, 32'h0000_0a5c);
    ssi(8'h90, 32'h0003_2000, 32'hc3a5_1e69);
    t_cont();
    chk(SSI_CLK, 2'b11);
    evt(0);
    wr(8'ha0, 1);
    evt(1);
    rc(8'ha4, 1);
    wr(8'ha4, 1);
    rc(8'ha4, 0);
    give_verdict();
  end
  initial
  begin
    #2_000_000;
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
